// file: core/iso_sync_consts.vh
`ifndef ISO_SYNC_CONSTS_VH
`define ISO_SYNC_CONSTS_VH

// Clock period in ns
`define CLK_PERIOD_NS 10
// Window grid unit in ns (1 us)
`define GRID_NS 1000
`define GRID_CYCLES (`GRID_NS / `CLK_PERIOD_NS)
// Window limits in grid units
`define WIN_MIN 16'h000A
`define WIN_MAX 16'h7D00
`define WIN_IN_DEFAULT 16'h00C8
`define WIN_OUT_DEFAULT 16'h00C8
// Longest bus cycle: 32 ms = 32000 grid units
`define CYCLE_MAX_MS 32
`define CYCLE_MAX_GRID (`CYCLE_MAX_MS * 1000)
// Jitter allowance in us
`define JITTER_US 10
`define JITTER_GRID (`JITTER_US * 1000 / `GRID_NS)
// Start-up cycles and failure limit
`define STARTUP_CYCLES 8'h96
`define FAIL_LIMIT 5'h19
// Data width and FIFO depth
`define DATA_W 16
`define FIFO_DEPTH 16

`endif

// file: core/iso_sync_fifo.v
`timescale 1ns/1ps
`include "iso_sync_consts.vh"

module iso_sync_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    input wire clkEn,
    input wire flush,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wrPtr_reg;
    reg [AW:0] rdPtr_reg;
    wire full;
    wire empty;
    wire doWr;
    wire doRd;

    assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    assign empty = wrPtr_reg == rdPtr_reg;
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_reg[AW-1:0]];
    assign doWr = clkEn && inValid && !full;
    assign doRd = clkEn && outReady && !empty;

    always @(posedge core_clk) begin
        if (doWr) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
        end else if (clkEn && flush) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + {{AW{1'b0}}, 1'b1};
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// file: core/isochronous_io_cycle_sync.v
`timescale 1ns/1ps
`include "iso_sync_consts.vh"

module isochronous_io_cycle_sync (
    // Clock, reset, enable
    input wire core_clk,
    input wire rst_b,
    input wire clkEn,
    // Configuration
    input wire syncEnable,
    input wire masterCycleEnable,
    input wire [15:0] inputReadWindow,
    input wire [15:0] outputWriteWindow,
    input wire [15:0] busCyclePeriod,
    input wire interferenceSuppressOn,
    input wire smoothingOn,
    input wire moduleSwapActive,
    // Input module delays, grid units
    input wire [15:0] inputModuleProcessingTimeA,
    input wire [15:0] inputModuleProcessingTimeB,
    // Bus side
    input wire globalControlFrame,
    input wire cycleViolation,
    // Output data stream from bus
    input wire outDataValid,
    output reg outDataReady,
    input wire [15:0] outData,
    // Terminal side
    output reg [15:0] terminalOut,
    output reg terminalOutStrobe,
    input wire [15:0] terminalIn,
    output reg [15:0] inputImage,
    output reg inputImageValid,
    // Status
    output reg isoActive,
    output reg isoGuaranteed,
    output reg outWindowOpen,
    output reg inWindowOpen,
    output reg stationFail,
    output reg [15:0] effInputWindow,
    output reg [15:0] effOutputWindow
);
    localparam ST_IDLE = 2'd0;
    localparam ST_STARTUP = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam ST_FAIL = 2'd3;

    // Snap a requested duration onto the legal grid range
    function [15:0] clampWin;
        input [15:0] req;
        input [15:0] dflt;
        begin
            if (req == 16'h0000) begin
                clampWin = dflt;
            end else if (req < `WIN_MIN) begin
                clampWin = `WIN_MIN;
            end else if (req > `WIN_MAX) begin
                clampWin = `WIN_MAX;
            end else begin
                clampWin = req;
            end
        end
    endfunction

    reg [1:0] state_reg;
    reg [6:0] gridDiv_reg;
    reg [15:0] cycleTimer_reg;
    reg [7:0] startupCnt_reg;
    reg [4:0] badCnt_reg;
    reg frameSeen_reg;
    reg [15:0] delayComp_reg;
    wire allowed;
    wire gridTick;
    wire [15:0] winIn;
    wire [15:0] winOut;
    wire [15:0] inStart;
    wire [15:0] minDelay;
    wire periodBad;
    wire frameLate;
    wire badCycle;
    wire fifoValid;
    wire [15:0] fifoData;
    wire fifoReady;
    wire fifoDrain;

    assign allowed = syncEnable && masterCycleEnable && !interferenceSuppressOn && !smoothingOn;
    assign gridTick = gridDiv_reg == (`GRID_CYCLES - 1);

    assign winIn = syncEnable ? clampWin(inputReadWindow, `WIN_IN_DEFAULT) : `WIN_IN_DEFAULT;
    assign winOut = syncEnable ? clampWin(outputWriteWindow, `WIN_OUT_DEFAULT) : `WIN_OUT_DEFAULT;

    assign minDelay = (inputModuleProcessingTimeA < inputModuleProcessingTimeB) ?
        inputModuleProcessingTimeA : inputModuleProcessingTimeB;

    // input window ends at next frame
    assign inStart = (busCyclePeriod > winIn) ? (busCyclePeriod - winIn) : 16'h0000;

    assign periodBad = busCyclePeriod > `CYCLE_MAX_GRID;
    assign frameLate = frameSeen_reg && (cycleTimer_reg > busCyclePeriod + `JITTER_GRID);
    assign badCycle = cycleViolation || (frameLate && gridTick);

    assign fifoDrain = outWindowOpen && isoActive;

    iso_sync_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(4)
    ) outFifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .flush(!isoActive),
        .inValid(outDataValid),
        .inReady(fifoReady),
        .inData(outData),
        .outValid(fifoValid),
        .outReady(fifoDrain),
        .outData(fifoData)
    );

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            gridDiv_reg <= 7'h00;
            cycleTimer_reg <= 16'h0000;
            startupCnt_reg <= 8'h00;
            badCnt_reg <= 5'h00;
            frameSeen_reg <= 1'b0;
            delayComp_reg <= 16'h0000;
            outDataReady <= 1'b0;
            terminalOut <= 16'h0000;
            terminalOutStrobe <= 1'b0;
            inputImage <= 16'h0000;
            inputImageValid <= 1'b0;
            isoActive <= 1'b0;
            isoGuaranteed <= 1'b0;
            outWindowOpen <= 1'b0;
            inWindowOpen <= 1'b0;
            stationFail <= 1'b0;
            effInputWindow <= `WIN_IN_DEFAULT;
            effOutputWindow <= `WIN_OUT_DEFAULT;
        end else if (clkEn) begin
            effInputWindow <= winIn;
            effOutputWindow <= winOut;
            delayComp_reg <= minDelay;
            outDataReady <= fifoReady;
            terminalOutStrobe <= 1'b0;
            inputImageValid <= 1'b0;
            gridDiv_reg <= gridTick ? 7'h00 : gridDiv_reg + 7'h01;
            if (globalControlFrame) begin
                cycleTimer_reg <= 16'h0000;
                gridDiv_reg <= 7'h00;
                frameSeen_reg <= 1'b1;
            end else if (gridTick && cycleTimer_reg != 16'hFFFF) begin
                cycleTimer_reg <= cycleTimer_reg + 16'h0001;
            end
            case (state_reg)
                ST_IDLE: begin
                    isoActive <= 1'b0;
                    isoGuaranteed <= 1'b0;
                    outWindowOpen <= 1'b0;
                    inWindowOpen <= 1'b0;
                    startupCnt_reg <= 8'h00;
                    badCnt_reg <= 5'h00;
                    if (allowed && !periodBad && !moduleSwapActive && globalControlFrame) begin
                        state_reg <= ST_STARTUP;
                        isoActive <= 1'b1;
                        outWindowOpen <= 1'b1;
                    end
                end
                ST_STARTUP, ST_RUN: begin
                    // swap or lost enable suspends timing
                    if (!allowed || moduleSwapActive || periodBad) begin
                        state_reg <= ST_IDLE;
                        isoActive <= 1'b0;
                        isoGuaranteed <= 1'b0;
                        frameSeen_reg <= 1'b0;
                    end else begin
                        if (globalControlFrame) begin
                            outWindowOpen <= 1'b1;
                            if (inWindowOpen) begin
                                inputImage <= terminalIn;
                                inputImageValid <= 1'b1;
                            end
                            inWindowOpen <= (inStart == 16'h0000);
                            if (state_reg == ST_STARTUP) begin
                                if (startupCnt_reg == `STARTUP_CYCLES - 8'h01) begin
                                    state_reg <= ST_RUN;
                                    isoGuaranteed <= 1'b1;
                                end
                                startupCnt_reg <= startupCnt_reg + 8'h01;
                            end
                        end else begin
                            if (cycleTimer_reg >= winOut) begin
                                outWindowOpen <= 1'b0;
                            end
                            // input may open while output open
                            if (cycleTimer_reg + delayComp_reg >= inStart) begin
                                inWindowOpen <= 1'b1;
                            end
                        end
                        // fail after over 25 bad cycles
                        if (badCycle) begin
                            if (badCnt_reg == `FAIL_LIMIT) begin
                                state_reg <= ST_FAIL;
                                stationFail <= 1'b1;
                                isoActive <= 1'b0;
                                isoGuaranteed <= 1'b0;
                            end else begin
                                badCnt_reg <= badCnt_reg + 5'h01;
                            end
                            if (frameLate) begin
                                cycleTimer_reg <= 16'h0000;
                            end
                        end
                    end
                end
                ST_FAIL: begin
                    outWindowOpen <= 1'b0;
                    inWindowOpen <= 1'b0;
                    if (!syncEnable) begin
                        state_reg <= ST_IDLE;
                        stationFail <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (fifoDrain && fifoValid) begin
                terminalOut <= fifoData;
                terminalOutStrobe <= 1'b1;
            end
        end
    end
endmodule

// file: bench/iso_sync_properties.sv
`timescale 1ns/1ps
module iso_sync_properties (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Configuration and bus
    input wire syncEnable,
    input wire masterCycleEnable,
    input wire interferenceSuppressOn,
    input wire smoothingOn,
    input wire moduleSwapActive,
    input wire globalControlFrame,
    input wire [15:0] busCyclePeriod,
    // Outputs watched
    input wire terminalOutStrobe,
    input wire inputImageValid,
    input wire isoActive,
    input wire isoGuaranteed,
    input wire outWindowOpen,
    input wire inWindowOpen,
    input wire stationFail,
    input wire [15:0] effInputWindow,
    input wire [15:0] effOutputWindow
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence frameSeen;
        globalControlFrame && isoActive;
    endsequence
    out_start_a: assert property (frameSeen |=> outWindowOpen) else $error("no out window");
    in_close_a: assert property (frameSeen |=> inWindowOpen == ($past(busCyclePeriod) <= effInputWindow))
        else $error("in window open");
    img_frame_a: assert property (inputImageValid |-> $past(globalControlFrame)) else $error("stray image");
    strobe_win_a: assert property (terminalOutStrobe |-> outWindowOpen || $past(outWindowOpen)) else $error("strobe");
    def_win_a: assert property (!syncEnable [*2] |-> effInputWindow == 16'h00C8 && effOutputWindow == 16'h00C8)
        else $error("not default");
    swap_stop_a: assert property (moduleSwapActive |=> !isoActive) else $error("iso in swap");
    no_master_a: assert property (!isoActive && !masterCycleEnable |=> !isoActive) else $error("iso no master");
    no_filter_a: assert property (!isoActive && (interferenceSuppressOn || smoothingOn) |=> !isoActive) else $error("f");
    guar_active_a: assert property (isoGuaranteed |-> isoActive) else $error("guaranteed idle");
    fail_stop_a: assert property (stationFail |-> !isoActive) else $error("iso after fail");
endmodule
bind isochronous_io_cycle_sync iso_sync_properties u_iso_sync_properties (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .syncEnable(syncEnable),
    .masterCycleEnable(masterCycleEnable),
    .interferenceSuppressOn(interferenceSuppressOn),
    .smoothingOn(smoothingOn),
    .moduleSwapActive(moduleSwapActive),
    .globalControlFrame(globalControlFrame),
    .busCyclePeriod(busCyclePeriod),
    .terminalOutStrobe(terminalOutStrobe),
    .inputImageValid(inputImageValid),
    .isoActive(isoActive),
    .isoGuaranteed(isoGuaranteed),
    .outWindowOpen(outWindowOpen),
    .inWindowOpen(inWindowOpen),
    .stationFail(stationFail),
    .effInputWindow(effInputWindow),
    .effOutputWindow(effOutputWindow)
);

// file: bench/fieldbus_master_model.sv
`timescale 1ns/1ps
module fieldbus_master_model (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Control
    input wire run,
    input wire [31:0] periodCycles,
    input wire [3:0] burstLen,
    // Bus side
    output reg globalControlFrame,
    output reg outDataValid,
    input wire outDataReady,
    output reg [15:0] outData
);
    reg [31:0] tickReg;
    reg [3:0] leftReg;
    reg [15:0] seqReg;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            globalControlFrame <= 1'b0;
            outDataValid <= 1'b0;
            outData <= 16'h0FFF;
            tickReg <= 32'h0000_0000;
            leftReg <= 4'h0;
            seqReg <= 16'h1000;
        end else begin
            globalControlFrame <= run && tickReg == 32'h0000_0000;
            if (run && tickReg == 32'h0000_0000) begin
                tickReg <= periodCycles - 32'h0000_0001;
                leftReg <= burstLen;
            end else if (tickReg != 32'h0000_0000) begin
                tickReg <= tickReg - 32'h0000_0001;
            end
            if (outDataValid && outDataReady) begin
                outDataValid <= 1'b0;
                outData <= ~outData;
            end else if (!outDataValid && leftReg != 4'h0 && outDataReady) begin
                outDataValid <= 1'b1;
                outData <= seqReg;
                seqReg <= seqReg + 16'h0001;
                leftReg <= leftReg - 4'h1;
            end
        end
    end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/1ps
`include "iso_sync_consts.vh"
module tb_top;
    reg core_clk = 0, rst_b = 0, syncEnable = 0, masterOn = 0, suppOn = 0, smoothOn = 0, swapOn = 0, viol = 0, run = 0;
    reg [15:0] winIn = 0, winOut = 0, period = 16'h0032, dlyA = 16'h0005, dlyB = 16'h0003, termIn = 16'hA5C3;
    reg [3:0] burst = 0;
    reg [15:0] expWord = 16'h1000;
    wire frame, dValid, dReady, strobe, imgValid, active, guar, outOpen, inOpen, fail;
    wire [15:0] dWord, termOut, image, effIn, effOut;
    integer miscompares = 0, checksDone = 0, n;
    always #5 core_clk = ~core_clk;
    fieldbus_master_model u_fieldbus_master_model (.core_clk(core_clk), .rst_b(rst_b), .run(run),
        .periodCycles(32'(period) * `GRID_CYCLES), .burstLen(burst), .globalControlFrame(frame),
        .outDataValid(dValid), .outDataReady(dReady), .outData(dWord));
    isochronous_io_cycle_sync u_isochronous_io_cycle_sync (.core_clk(core_clk), .rst_b(rst_b), .clkEn(1'b1),
        .syncEnable(syncEnable), .masterCycleEnable(masterOn), .inputReadWindow(winIn), .outputWriteWindow(winOut),
        .busCyclePeriod(period), .interferenceSuppressOn(suppOn), .smoothingOn(smoothOn), .moduleSwapActive(swapOn),
        .inputModuleProcessingTimeA(dlyA), .inputModuleProcessingTimeB(dlyB), .globalControlFrame(frame),
        .cycleViolation(viol), .outDataValid(dValid), .outDataReady(dReady), .outData(dWord), .terminalOut(termOut),
        .terminalOutStrobe(strobe), .terminalIn(termIn), .inputImage(image), .inputImageValid(imgValid),
        .isoActive(active), .isoGuaranteed(guar), .outWindowOpen(outOpen), .inWindowOpen(inOpen),
        .stationFail(fail), .effInputWindow(effIn), .effOutputWindow(effOut));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checksDone, miscompares);
            if (miscompares == 0 && checksDone > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task waitFrame;
        begin
            n = 0;
            while (frame !== 1'b1 && n < 6000) begin
                @(negedge core_clk);
                n = n + 1;
            end
            chk(16'(n < 6000), 16'h0001);
        end
    endtask
    task settle(input integer c);
        begin
            repeat (c) @(posedge core_clk);
            #1;
        end
    endtask
    task pulse;
        begin
            @(posedge core_clk);
            viol <= 1'b1;
            @(posedge core_clk);
            viol <= 1'b0;
        end
    endtask
    // Terminal words in send order
    always @(negedge core_clk) begin
        if (strobe === 1'b1) begin
            chk(termOut, expWord);
            expWord = expWord + 16'h0001;
        end
    end
    initial begin
        #1_000_000;
        miscompares = miscompares + 1;
        give_verdict;
    end
    initial begin
        settle(3);
        rst_b <= 1'b1;
        winIn <= 16'h0005;
        winOut <= 16'h0014;
        settle(3);
        chk(effIn, 16'h00C8);
        $display("test defaults done");
        syncEnable <= 1'b1;
        run <= 1'b1;
        settle(3);
        chk(effIn, 16'h000A);
        chk(effOut, 16'h0014);
        waitFrame;
        settle(1);
        chk(16'(active), 16'h0000);
        masterOn <= 1'b1;
        suppOn <= 1'b1;
        waitFrame;
        settle(1);
        chk(16'(active), 16'h0000);
        $display("test refusals done");
        suppOn <= 1'b0;
        burst <= 4'h4;
        waitFrame;
        settle(1);
        chk({active, outOpen}, 16'h0003);
        burst <= 4'h0;
        n = 0;
        while (outOpen === 1'b1 && n < 9000) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk(16'((n + 50) / 100), 16'h0014);
        while (inOpen !== 1'b1 && n < 9000) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk(16'((n + 50) / 100), 16'h0025);
        waitFrame;
        chk(16'(inOpen), 16'h0001);
        settle(1);
        chk({15'h0000, imgValid}, 16'h0001);
        chk(image, 16'hA5C3);
        chk(expWord, 16'h1004);
        $display("test windows done");
        swapOn <= 1'b1;
        settle(2);
        chk(16'(active), 16'h0000);
        swapOn <= 1'b0;
        waitFrame;
        settle(1);
        chk(16'(active), 16'h0001);
        $display("test swap done");
        repeat (25) pulse;
        settle(2);
        chk(16'(fail), 16'h0000);
        pulse;
        settle(2);
        chk({fail, active}, 16'h0002);
        syncEnable <= 1'b0;
        settle(3);
        chk(16'(fail), 16'h0000);
        $display("test failure done");
        period <= 16'h0002;
        syncEnable <= 1'b1;
        waitFrame;
        settle(1);
        chk({active, outOpen}, 16'h0003);
        repeat (149) begin
            waitFrame;
            settle(1);
        end
        chk({outOpen, inOpen}, 16'h0003);
        chk(16'(guar), 16'h0000);
        waitFrame;
        settle(1);
        chk(16'(guar), 16'h0001);
        swapOn <= 1'b1;
        settle(2);
        chk({guar, active}, 16'h0000);
        swapOn <= 1'b0;
        $display("test startup done");
        give_verdict;
    end
endmodule
